//--- common/gcsp_defines.svh
// Constants for the gain-control serial/parallel front end
`ifndef GCSP_DEFINES_SVH
`define GCSP_DEFINES_SVH
`define GCSP_GAIN_W       6
`define GCSP_FRAME_BITS   5'h10
`define GCSP_CMD_BITS     5'h08
`define GCSP_DIR_BIT      7
`define GCSP_CHSEL_BIT    0
`define GCSP_EN_BIT       7
`define GCSP_GAIN_MSB     6
`define GCSP_GAIN_LSB     1
`define GCSP_ADDR_RESET   1'b0
`define GCSP_GAIN_RESET   6'h00
`define GCSP_SEN_RESET    1'b1
`endif

//--- common/gcsp_pkg.sv
// Types for the gain-control serial/parallel front end
`default_nettype none
package gcsp_pkg;
    typedef enum logic [1:0]
    {
        GCSP_RESERVED = 2'h0,
        GCSP_PULSE    = 2'h1,
        GCSP_SERIAL   = 2'h2,
        GCSP_PARALLEL = 2'h3
    } gcsp_mode_t;

    typedef struct packed
    {
        logic       enable;
        logic [5:0] gain;
    } gcsp_chan_t;
endpackage : gcsp_pkg
`default_nettype wire

//--- rtl/gcsp_gain_ctrl.sv
// Gain-control front end: mode decode, parallel latches, serial register port
//
// Contract
// - Decode mode pins: 11 parallel, 10 serial, 01 pulse, 00 reserved.
// - Serial functions active only when mode pins read high then low.
// - Parallel: 6-bit gain code applied immediately while hold is low.
// - Hold rising freezes gain; later code changes ignored until hold low.
// - Hold tied low gives transparent operation, gain follows pins.
// - Enable pin low disables channel; stored gain kept and restored.
// - Unconnected enable pin reads as high, channel enabled.
// - Serial mode: channel active only if pin and serial enable both set.
// - Serial mode ignores the parallel hold inputs.
// - Sample data on serial clock rise, change output on fall.
// - Each select assertion restarts access from the first bit.
// - Access needs at least 16 clocks, later clocks ignored; early select rise writes nothing.
// - Select rising captures address and, on write, updates register.
// - Serial output open drain, released whenever select is not asserted.
// - Addressed register shifted out on the eighth to fifteenth falling edges.
// - Register address defaults to zero after power-up.
// - Command byte: top bit read, six zero bits, low bit channel.
// - Data byte: enable, gains 16 to 0.5 dB, reserved zero bit.
// - Read access ignores data byte and changes no register.
`include "gcsp_defines.svh"
`default_nettype none
module gcsp_gain_ctrl
(
    input  wire logic                     clk,              // System clock
    input  wire logic                     resetn,           // Async reset, active low
    input  wire logic                     clk_en,           // Freezes all state while low
    input  wire logic                     mode_select_hi,   // Mode pin, first
    input  wire logic                     mode_select_lo,   // Mode pin, second
    input  wire logic [1:0]               chan_enable_pin,  // Enable pins, bit0 A, bit1 B (pulled up outside)
    input  wire logic [1:0]               chan_hold,        // Hold pins, bit0 A, bit1 B
    input  wire logic [5:0]               gain_code_a,      // Parallel gain code A
    input  wire logic [5:0]               gain_code_b,      // Parallel gain code B
    input  wire logic                     serial_clk,       // Serial clock pin
    input  wire logic                     select_n,         // Chip select pin, active low
    input  wire logic                     serial_in,        // Serial data in pin
    output var  logic                     serial_out_o,     // Serial out level (always 0)
    output var  logic                     serial_out_oe,    // Serial out pull-low enable
    output var  logic [1:0]               chan_active,      // Channel powered, bit0 A
    output var  logic [5:0]               chan_a_gain,      // Applied gain A
    output var  logic [5:0]               chan_b_gain,      // Applied gain B
    output var  gcsp_pkg::gcsp_mode_t     mode              // Decoded mode
);
    // ********************************************************
    // Input synchronisers
    // ********************************************************
    // Every pin crosses two flops before any logic reads it, so all
    // pin-derived behaviour lags the pins by two to three clk cycles
    localparam int SW = 21;
    // Select idles high; a low reset copy would fake a select fall
    localparam logic [SW-1:0] SYNC_IDLE = 21'h000002;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] next_sync1;
    logic [SW-1:0] next_sync2;

    always_comb
    begin
        next_sync1 = {mode_select_hi, mode_select_lo, chan_enable_pin, chan_hold,
                      gain_code_a, gain_code_b, serial_clk, select_n, serial_in};
        next_sync2 = sync1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
        end
        else if (clk_en)
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
        end
    end

    logic       s_hi;
    logic       s_lo;
    logic [1:0] s_en;
    logic [1:0] s_hold;
    logic [5:0] s_code_a;
    logic [5:0] s_code_b;
    logic       s_sck;
    logic       s_sel_n;
    logic       s_sdi;
    assign {s_hi, s_lo, s_en, s_hold, s_code_a, s_code_b, s_sck, s_sel_n, s_sdi} = sync2;

    // ********************************************************
    // Mode decode and edge detection
    // ********************************************************
    gcsp_pkg::gcsp_mode_t cur_mode;
    logic                 sck_d;
    logic                 sel_n_d;
    logic                 next_sck_d;
    logic                 next_sel_n_d;
    logic                 sck_rise;
    logic                 sck_fall;
    logic                 sel_fall;
    logic                 sel_rise;
    logic                 serial_mode;

    // Edges of the serial clock and select are found on the synchronised
    // copies; the serial clock half period must span several clk cycles
    // or an edge is missed
    always_comb
    begin
        cur_mode     = gcsp_pkg::gcsp_mode_t'({s_hi, s_lo});
        serial_mode  = (cur_mode == gcsp_pkg::GCSP_SERIAL);
        next_sck_d   = s_sck;
        next_sel_n_d = s_sel_n;
        sck_rise     = s_sck && !sck_d;
        sck_fall     = !s_sck && sck_d;
        sel_fall     = !s_sel_n && sel_n_d;
        sel_rise     = s_sel_n && !sel_n_d;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sck_d   <= 1'b0;
            sel_n_d <= 1'b1;
        end
        else if (clk_en)
        begin
            sck_d   <= next_sck_d;
            sel_n_d <= next_sel_n_d;
        end
    end

    // ********************************************************
    // Serial shifter and channel registers
    // ********************************************************
    logic [15:0]         shift_in;
    logic [4:0]          bit_cnt;
    logic [7:0]          shift_out;
    logic                addr;
    logic                drive;
    gcsp_pkg::gcsp_chan_t regs [2];
    logic [15:0]         next_shift_in;
    logic [4:0]          next_bit_cnt;
    logic [7:0]          next_shift_out;
    logic                next_addr;
    logic                next_drive;
    gcsp_pkg::gcsp_chan_t next_regs [2];
    logic [5:0]          par_code [2];
    logic                cmd_addr;

    assign par_code[0] = s_code_a;
    assign par_code[1] = s_code_b;
    assign cmd_addr    = shift_in[8 + `GCSP_CHSEL_BIT];

    // Frame: 16 rises shift the command byte then the data byte, MSB first.
    // After the eighth rise the channel named by the command is loaded for
    // return; the falls that follow pull the line low for each zero bit.
    // The count saturates at 16 so extra clocks are ignored, and a select
    // rise with any other count leaves every register untouched.
    // Only the command's direction bit decides between write and read.

    always_comb
    begin
        next_shift_in  = shift_in;
        next_bit_cnt   = bit_cnt;
        next_shift_out = shift_out;
        next_addr      = addr;
        next_drive     = drive;
        next_regs      = regs;
        if (!serial_mode || s_sel_n)
        begin
            next_drive = 1'b0;
        end
        if (serial_mode)
        begin
            if (sel_fall)
            begin
                next_bit_cnt  = 5'h00;
                next_shift_in = 16'h0000;
            end
            else if (!s_sel_n && sck_rise && bit_cnt != `GCSP_FRAME_BITS)
            begin
                next_shift_in = {shift_in[14:0], s_sdi};
                next_bit_cnt  = bit_cnt + 5'h01;
                if (bit_cnt + 5'h01 == `GCSP_CMD_BITS)
                begin
                    // The eighth bit is the channel bit, still on the data pin
                    next_shift_out = {regs[s_sdi].enable, regs[s_sdi].gain, 1'b0};
                end
            end
            else if (!s_sel_n && sck_fall && bit_cnt >= `GCSP_CMD_BITS
                     && bit_cnt < `GCSP_FRAME_BITS)
            begin
                next_drive     = !shift_out[7];
                next_shift_out = {shift_out[6:0], 1'b0};
            end
            if (sel_rise && bit_cnt == `GCSP_FRAME_BITS)
            begin
                next_addr = cmd_addr;
                if (!shift_in[8 + `GCSP_DIR_BIT])
                begin
                    next_regs[cmd_addr].enable = shift_in[`GCSP_EN_BIT];
                    next_regs[cmd_addr].gain   = shift_in[`GCSP_GAIN_MSB:`GCSP_GAIN_LSB];
                end
            end
        end
        // Parallel latches: transparent while hold low, frozen while high.
        // The enable bits are forced on so only the pins gate the channels;
        // in the reserved and pulse modes nothing here touches the gains.
        if (cur_mode == gcsp_pkg::GCSP_PARALLEL)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (!s_hold[i])
                begin
                    next_regs[i].gain = par_code[i];
                end
                next_regs[i].enable = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_in  <= 16'h0000;
            bit_cnt   <= 5'h00;
            shift_out <= 8'h00;
            addr      <= `GCSP_ADDR_RESET;
            drive     <= 1'b0;
            for (int i = 0; i < 2; i++)
            begin
                regs[i].enable <= `GCSP_SEN_RESET;
                regs[i].gain   <= `GCSP_GAIN_RESET;
            end
        end
        else if (clk_en)                                          // reserved/pulse: regs untouched
        begin
            shift_in  <= next_shift_in;
            bit_cnt   <= next_bit_cnt;
            shift_out <= next_shift_out;
            addr      <= next_addr;
            drive     <= next_drive;
            regs      <= next_regs;
        end
    end

    // ********************************************************
    // Registered outputs
    // ********************************************************
    // Outputs follow the next state so a change shows one cycle sooner.
    // A disabled channel keeps its gain: only the active bit drops.
    logic [1:0]           next_active;
    logic [5:0]           next_gain_a;
    logic [5:0]           next_gain_b;
    logic                 next_oe;
    gcsp_pkg::gcsp_mode_t next_mode;

    for (genvar g = 0; g < 2; g++)
    begin : g_active
        assign next_active[g] = s_en[g] && (serial_mode ? next_regs[g].enable : 1'b1);
    end

    always_comb
    begin
        next_oe     = next_drive;
        next_gain_a = next_regs[0].gain;
        next_gain_b = next_regs[1].gain;
        next_mode   = cur_mode;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            serial_out_o  <= 1'b0;
            serial_out_oe <= 1'b0;
            chan_active   <= 2'h0;
            chan_a_gain   <= `GCSP_GAIN_RESET;
            chan_b_gain   <= `GCSP_GAIN_RESET;
            mode          <= gcsp_pkg::GCSP_RESERVED;
        end
        else if (clk_en)
        begin
            serial_out_o  <= 1'b0;
            serial_out_oe <= next_oe;
            chan_active   <= next_active;
            chan_a_gain   <= next_gain_a;
            chan_b_gain   <= next_gain_b;
            mode          <= next_mode;
        end
    end
endmodule : gcsp_gain_ctrl
`default_nettype wire

//--- common/unused_placeholder_none.sv
// Empty: no further content
`default_nettype none
`default_nettype wire

//--- dv/gcsp_gain_ctrl_sva.sv
// Port-level checker for the gain-control front end
`default_nettype none
module gcsp_gain_ctrl_sva
(
    input wire logic                 clk,             // System clock
    input wire logic                 resetn,          // Reset, active low
    input wire logic                 clk_en,          // Clock enable
    input wire logic                 mode_select_hi,  // Mode pin, first
    input wire logic                 mode_select_lo,  // Mode pin, second
    input wire logic [1:0]           chan_enable_pin, // Enable pins
    input wire logic [1:0]           chan_hold,       // Hold pins
    input wire logic [5:0]           gain_code_a,     // Parallel code A
    input wire logic [5:0]           gain_code_b,     // Parallel code B
    input wire logic                 serial_clk,      // Serial clock
    input wire logic                 select_n,        // Select, active low
    input wire logic                 serial_in,       // Serial data in
    input wire logic                 serial_out_o,    // Serial out level
    input wire logic                 serial_out_oe,   // Pull-low enable
    input wire logic [1:0]           chan_active,     // Channel active
    input wire logic [5:0]           chan_a_gain,     // Applied gain A
    input wire logic [5:0]           chan_b_gain,     // Applied gain B
    input wire gcsp_pkg::gcsp_mode_t mode             // Decoded mode
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire par = mode == gcsp_pkg::GCSP_PARALLEL;
    chk_oe_release: assert property (select_n[*5] |-> !serial_out_oe)
        else $error("pull-low enabled while deselected");
    chk_od_level: assert property (serial_out_o == 1'b0)
        else $error("open-drain level not low");
    chk_mode_decode: assert property ($stable({mode_select_hi, mode_select_lo})[*5] |->
        mode == gcsp_pkg::gcsp_mode_t'({mode_select_hi, mode_select_lo})) else $error("mode decode wrong");
    chk_par_follow: assert property ((par && !chan_hold[0] && $stable(gain_code_a))[*5] |->
        chan_a_gain == gain_code_a) else $error("gain A not following code");
    chk_hold_freeze: assert property ((par && chan_hold[1])[*6] |-> $stable(chan_b_gain))
        else $error("gain B moved while held");
    chk_stored_hold: assert property ((mode inside {gcsp_pkg::GCSP_RESERVED, gcsp_pkg::GCSP_PULSE})[*2] |->
        $stable({chan_a_gain, chan_b_gain})) else $error("gain moved in holding mode");
    chk_active_and: assert property ((par && $stable(chan_enable_pin))[*5] |-> chan_active == chan_enable_pin
        ) else $error("active differs from enable pins");
    chk_active_sub: assert property ((chan_active & ~$past(chan_enable_pin, 3)) == 2'h0)
        else $error("channel active with pin low");
    chk_serial_quiet: assert property ((mode == gcsp_pkg::GCSP_SERIAL && !select_n)[*8] |->
        $stable({chan_a_gain, chan_b_gain})) else $error("gain moved inside access");
    cov_read_out: cover property (!select_n && serial_out_oe);
    cov_hold: cover property (par && chan_hold[1] && $changed(gain_code_b));
    cov_reserved: cover property (mode == gcsp_pkg::GCSP_RESERVED && $changed(gain_code_a));
endmodule : gcsp_gain_ctrl_sva
bind gcsp_gain_ctrl gcsp_gain_ctrl_sva u_sva (.*);
`default_nettype wire

//--- dv/gcsp_spi_host.sv
// Host serial master model with a pulled-up return line
`default_nettype none
module gcsp_spi_host
(
    output var  logic       serial_clk, // Serial clock, parked low
    output var  logic       select_n,   // Select, active low
    output var  logic       serial_in,  // Data to device
    input  wire logic       out_o,      // Device drive level
    input  wire logic       out_oe,     // Device pull-low enable
    output var  logic [7:0] rd          // Last byte returned
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Frames
    // ********
    wire line_lvl = out_oe ? out_o : 1'b1;
    initial
    begin
        serial_clk = 1'b0;
        select_n = 1'b1;
        serial_in = 1'b0;
        rd = 8'h00;
    end
    task automatic xfer(input logic [15:0] w, input int n);
        #1.3 select_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            serial_in = w[15 - i];
            #24 serial_clk = 1'b1;
            if (i > 7)
                rd = {rd[6:0], line_lvl};
            #24 serial_clk = 1'b0;
        end
        #24 select_n = 1'b1;
        serial_in = ~serial_in;
        #40;
    endtask : xfer
endmodule : gcsp_spi_host
`default_nettype wire

//--- dv/test_gain_control_serial_parallel.sv
// Self-checking bench for the gain-control front end
`default_nettype none
module test_gain_control_serial_parallel;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk = 1'b0;
    logic                 resetn = 1'b0;
    logic [1:0]           msel = 2'h3;
    logic [1:0]           en_pin = 2'h3;
    logic [1:0]           hold = 2'h0;
    logic [5:0]           code_a = 6'h00;
    logic [5:0]           code_b = 6'h00;
    logic                 sclk, sel_n, sdi, so_o, so_oe;
    logic                 snap = 1'b0;
    logic [1:0]           act;
    logic [5:0]           ga, gb;
    gcsp_pkg::gcsp_mode_t mode;
    logic [7:0]           rd;
    logic [6:0]           reg_a, reg_b;
    logic [23:0]          exp_q[$];
    integer               seed = 3;
    int                   fails = 0;
    int                   checked = 0;
    always #2 clk = ~clk;
    gcsp_gain_ctrl dut (.clk(clk), .resetn(resetn), .clk_en(1'b1), .mode_select_hi(msel[1]), .mode_select_lo(msel[0]),
        .chan_enable_pin(en_pin), .chan_hold(hold), .gain_code_a(code_a), .gain_code_b(code_b), .serial_clk(sclk),
        .select_n(sel_n), .serial_in(sdi), .serial_out_o(so_o), .serial_out_oe(so_oe), .chan_active(act),
        .chan_a_gain(ga), .chan_b_gain(gb), .mode(mode));
    gcsp_spi_host host (.serial_clk(sclk), .select_n(sel_n), .serial_in(sdi), .out_o(so_o), .out_oe(so_oe), .rd(rd));
    // ********
    // Checking
    // ********
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH outputs expected %h seen %h", exp, seen);
        end
    endtask : check
    task automatic note(input logic [1:0] m, input logic [1:0] a, input logic [5:0] x, input logic [5:0] y,
                        input logic [7:0] r);
        repeat (12) @(negedge clk);
        exp_q.push_back({r, m, a, x, y});
        snap = 1'b1;
        @(negedge clk);
        snap = 1'b0;
    endtask : note
    always @(posedge clk)
        if (snap)
        begin
            #1;
            check({rd, mode, act, ga, gb}, exp_q.pop_front());
        end
    task automatic close_out();
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    initial
    begin
        #20000;
        fails++;
        close_out();
    end
    // ********
    // Stimulus
    // ********
    initial
    begin
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            hold = 2'h3;
            @(negedge clk);
            code_a = 6'($random(seed));
            code_b = 6'($random(seed));
            @(negedge clk);
            hold = 2'h0;
            note(2'h3, 2'h3, code_a, code_b, 8'h00);
        end
        hold = 2'h2;
        @(negedge clk);
        code_b = ~code_b;
        note(2'h3, 2'h3, code_a, ~code_b, 8'h00);
        hold = 2'h0;
        note(2'h3, 2'h3, code_a, code_b, 8'h00);
        en_pin = 2'h2;
        note(2'h3, 2'h2, code_a, code_b, 8'h00);
        en_pin = 2'h3;
        note(2'h3, 2'h3, code_a, code_b, 8'h00);
        msel = 2'h2;
        hold = 2'h1;
        reg_a = {1'b1, 6'($random(seed))};
        reg_b = {1'b0, 6'($random(seed))};
        repeat (8) @(negedge clk);
        host.xfer({8'h00, reg_a, 1'b0}, 16);
        host.xfer({8'h01, reg_b, 1'b0}, 16);
        host.xfer({8'h00, ~reg_a, 1'b0}, 12);
        host.xfer({8'h80, ~reg_a, 1'b0}, 16);
        note(2'h2, 2'h1, reg_a[5:0], reg_b[5:0], {reg_a, 1'b0});
        host.xfer({8'h81, 8'h5a}, 16);
        note(2'h2, 2'h1, reg_a[5:0], reg_b[5:0], {reg_b, 1'b0});
        hold = 2'h0;
        for (int m = 0; m < 2; m++)
        begin
            msel = 2'(m);
            repeat (8) @(negedge clk);
            code_a = 6'($random(seed));
            code_b = 6'($random(seed));
            note(2'(m), 2'h3, reg_a[5:0], reg_b[5:0], {reg_b, 1'b0});
        end
        close_out();
    end
endmodule : test_gain_control_serial_parallel
`default_nettype wire
